// file: field_move_displaced_to_register.sv
/*
 Decode and execution of the displaced field load into a register.
 Assumes a memory port that answers a word read one or more cycles
 later with a valid pulse, and a register file read combinationally.
*/
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
module field_move_displaced_to_register (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr_word,
    output logic o_instr_ready,
    output logic o_illegal,
    input wire logic [4:0] i_field_length_first,
    input wire logic i_field_extend_first,
    input wire logic [4:0] i_field_length_second,
    input wire logic i_field_extend_second,
    output logic [4:0] o_reg_rd_num,
    input wire logic [31:0] i_reg_rd_data,
    output logic o_mem_rd,
    output logic [31:0] o_mem_word_addr,
    input wire logic i_mem_valid,
    input wire logic [15:0] i_mem_data,
    output logic o_reg_wr,
    output logic [4:0] o_reg_wr_num,
    output logic [31:0] o_reg_wr_data,
    output logic o_flag_n,
    output logic o_flag_z,
    output logic o_flag_v,
    output logic o_flags_wr,
    output logic o_done
);
    import fmove_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DISP = 3'b001,
        ST_READ = 3'b011,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b110
    } state_e;

    state_e state_q, state_d;
    logic [15:0] op_q;
    logic [31:0] addr_q;
    logic [47:0] words_q;
    logic [1:0] cnt_q;
    logic [1:0] need_q;
    logic [31:0] value;
    logic fsel;
    logic [4:0] len_code;
    logic sign_ext;
    logic [5:0] len_full;
    logic [5:0] span;
    logic [31:0] bit_addr;
    logic is_match;
    logic rfile;

    assign is_match = i_instr_word[OPC_HI:OPC_LO] == OPC_PATTERN;
    assign fsel = op_q[FSEL_BIT];
    assign rfile = op_q[RFILE_BIT];
    // Settings come from the configuration inputs, never the opcode
    assign len_code = fsel ? i_field_length_second
                           : i_field_length_first;
    assign sign_ext = fsel ? i_field_extend_second
                           : i_field_extend_first;
    assign len_full = (len_code == 5'h00) ? 6'h20 : {1'b0, len_code};
    assign span = {2'b00, addr_q[3:0]} + len_full;
    assign o_reg_rd_num = {rfile, op_q[SRC_HI:SRC_LO]};
    assign bit_addr = i_reg_rd_data
                    + {{16{i_instr_word[15]}}, i_instr_word};
    assign o_instr_ready = (state_q == ST_IDLE) || (state_q == ST_DISP);
    assign o_mem_rd = (state_q == ST_READ);
    assign o_mem_word_addr = {4'h0, addr_q[31:4]} + {30'h0, cnt_q};

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (i_instr_valid && is_match) state_d = ST_DISP;
            ST_DISP: if (i_instr_valid) state_d = ST_READ;
            ST_READ: state_d = ST_WAIT;
            ST_WAIT: begin
                if (i_mem_valid)
                    state_d = (cnt_q == need_q) ? ST_DONE : ST_READ;
            end
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    field_extract u_extract (
        .i_words(words_q),
        .i_bit_offset(addr_q[3:0]),
        .i_len_code(len_code),
        .i_sign_extend(sign_ext),
        .o_value(value)
    );

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= ST_IDLE;
            op_q <= 16'h0000;
            addr_q <= 32'h00000000;
            words_q <= 48'h000000000000;
            cnt_q <= 2'h0;
            need_q <= 2'h0;
            o_illegal <= 1'b0;
        end else if (i_clk_en) begin
            state_q <= state_d;
            o_illegal <= (state_q == ST_IDLE) && i_instr_valid && !is_match;
            if (state_q == ST_IDLE && i_instr_valid && is_match) begin
                op_q <= i_instr_word;
            end
            if (state_q == ST_DISP && i_instr_valid) begin
                addr_q <= bit_addr;
                cnt_q <= 2'h0;
                words_q <= 48'h000000000000;
            end
            if (state_q == ST_READ) begin
                need_q <= (span > 6'h20) ? 2'h2
                        : ((span > 6'h10) ? 2'h1 : 2'h0);
            end
            if (state_q == ST_WAIT && i_mem_valid) begin
                words_q[cnt_q * WORD_W +: WORD_W] <= i_mem_data;
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end

    // Outputs registered one cycle after capture to keep the data path short
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reg_wr <= 1'b0;
            o_reg_wr_num <= 5'h00;
            o_reg_wr_data <= 32'h00000000;
            o_flag_n <= 1'b0;
            o_flag_z <= 1'b0;
            o_flag_v <= 1'b0;
            o_flags_wr <= 1'b0;
            o_done <= 1'b0;
        end else if (i_clk_en) begin
            o_reg_wr <= (state_q == ST_DONE);
            o_flags_wr <= (state_q == ST_DONE);
            o_done <= (state_q == ST_DONE);
            if (state_q == ST_DONE) begin
                o_reg_wr_num <= {rfile, op_q[DST_HI:DST_LO]};
                // Last word only lands in words_q at the edge into done
                o_reg_wr_data <= value;
                o_flag_n <= value[DATA_W-1];
                o_flag_z <= (value == 32'h00000000);
                o_flag_v <= 1'b0;
            end
        end
    end
endmodule // field_move_displaced_to_register

// file: fmove_pkg.sv
/*
 Constants for the displaced field-load unit: opcode layout, field
 settings, memory word size and data width.
 Assumes a 32-bit register file and a 16-bit wide, bit-addressed memory.
*/
// Function
// - Opcode bits 15..10 equal 101101, bit9 selects
// - Second word is signed 16-bit displacement
// - Bit address is source register plus displacement
// - Flag zero picks first settings, one second
// - Field length one to thirty-two bits
// - Right-justify, sign or zero extend to 32
// - Negative flag follows extended result sign
// - Zero flag set when extended result zero
// - Overflow cleared, carry left unchanged
// - Length and extension come from configuration settings
package fmove_pkg;
    localparam logic [5:0] OPC_PATTERN = 6'h2d;
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 10;
    localparam int FSEL_BIT = 9;
    localparam int SRC_HI = 8;
    localparam int SRC_LO = 5;
    localparam int RFILE_BIT = 4;
    localparam int DST_HI = 3;
    localparam int DST_LO = 0;
    localparam int WORD_W = 16;
    localparam int DATA_W = 32;
    localparam int LEN_W = 5;
    localparam int BITPOS_W = 4;
endpackage

// file: field_extract.sv
/*
 Field alignment: takes three consecutive memory words, a bit offset
 and a field length and returns the field right-justified and extended.
 Assumes the caller has captured the words covering the whole field.
*/
`timescale 1ns/10ps
module field_extract (
    input wire logic [47:0] i_words,
    input wire logic [3:0] i_bit_offset,
    input wire logic [4:0] i_len_code,
    input wire logic i_sign_extend,
    output logic [31:0] o_value
);
    import fmove_pkg::*;
    logic [47:0] shifted;
    logic [31:0] raw;
    logic [31:0] mask;
    logic [5:0] len;
    logic sign_bit;

    // Length code 0 stands for a 32-bit field
    assign len = (i_len_code == 5'h00) ? 6'h20 : {1'b0, i_len_code};
    assign shifted = i_words >> i_bit_offset;
    assign mask = (len == 6'h20) ? 32'hffffffff
                : ((32'h00000001 << len[4:0]) - 32'h00000001);
    assign raw = shifted[31:0] & mask;
    assign sign_bit = shifted[len - 6'h01];
    assign o_value = (i_sign_extend && sign_bit) ? (raw | ~mask) : raw;
endmodule // field_extract

// file: fmove_chk.sv
/*
 Checker for the displaced field load: flags, pulses, latencies.
 Assumes the clock enable is held high by the bench.
*/
`timescale 1ns/10ps
module fmove_chk (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [15:0] i_instr_word,
    input wire logic i_mem_valid,
    input wire logic o_instr_ready,
    input wire logic o_illegal,
    input wire logic o_mem_rd,
    input wire logic o_reg_wr,
    input wire logic [31:0] o_reg_wr_data,
    input wire logic o_flag_n,
    input wire logic o_flag_z,
    input wire logic o_flag_v,
    input wire logic o_flags_wr,
    input wire logic o_done
);
    import fmove_pkg::*;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    property p_ill;
        o_illegal |-> $past(i_instr_word[OPC_HI:OPC_LO]) != OPC_PATTERN;
    endproperty
    a_ill: assert property (p_ill)
        else $error("illegal on good opcode");
    property p_n;
        o_flags_wr |-> o_flag_n == o_reg_wr_data[DATA_W-1];
    endproperty
    a_n: assert property (p_n)
        else $error("negative flag wrong");
    property p_z;
        o_flags_wr |-> o_flag_z == (o_reg_wr_data == 32'h00000000);
    endproperty
    a_z: assert property (p_z)
        else $error("zero flag wrong");
    property p_v;
        o_flags_wr |-> !o_flag_v;
    endproperty
    a_v: assert property (p_v)
        else $error("overflow flag set");
    // Write only leaves a busy cycle, together with flags and done
    property p_wr;
        o_reg_wr |-> o_flags_wr && o_done && $past(!o_instr_ready);
    endproperty
    a_wr: assert property (p_wr)
        else $error("write without flags");
    property p_lat;
        o_reg_wr |-> $past(i_mem_valid, 2);
    endproperty
    a_lat: assert property (p_lat)
        else $error("write latency wrong");
    property p_rd;
        o_mem_rd |-> !o_instr_ready ##1 !o_mem_rd;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read pulse wrong");
    property p_idle;
        o_done |=> o_instr_ready;
    endproperty
    a_idle: assert property (p_idle)
        else $error("not idle after done");
    // Illegal and flag cases worth seeing at least once
    c_ill: cover property (o_illegal);
    c_z: cover property (o_flags_wr && o_flag_z);
    c_n: cover property (o_flags_wr && o_flag_n);
endmodule // fmove_chk

bind field_move_displaced_to_register fmove_chk u_chk (.*);

// file: fmove_mem.sv
/*
 Bit-addressed memory model answering word reads after 0 to 2 waits.
 Assumes one read outstanding at a time.
*/
`timescale 1ns/10ps
module fmove_mem (
    input wire logic i_ref_clk,
    input wire logic i_rd,
    input wire logic [31:0] i_addr,
    output logic o_valid = 0,
    output logic [15:0] o_data = 0
);
    logic [1:0] cnt = 0;
    logic pend = 0;
    logic [31:0] a = 0;
    function automatic logic [15:0] word(input logic [31:0] w);
        return w[15:0] * 16'h9e37 ^ w[31:16];
    endfunction
    always @(posedge i_ref_clk) begin
        logic [1:0] n;
        logic [31:0] ad;
        n = i_rd ? 2'($urandom_range(2)) : cnt;
        ad = i_rd ? i_addr : a;
        o_valid <= (i_rd | pend) && n == 0;
        // Released bus shows the last word inverted, then alternates with it each cycle
        o_data <= ((i_rd | pend) && n == 0) ? word(ad) : ~o_data;
        pend <= (i_rd | pend) && n != 0;
        cnt <= n - 2'h1;
        a <= ad;
    end
endmodule // fmove_mem

// file: test_field_move_displaced_to_register.sv
/*
 Self-checking bench for the displaced field load.
 Assumes the memory model in fmove_mem; clock enable held high.
*/
`timescale 1ns/10ps
module test_field_move_displaced_to_register;
    import fmove_pkg::*;
    logic i_ref_clk = 0, i_resetn = 0, i_clk_en = 1, i_instr_valid = 0;
    logic [15:0] i_instr_word = 0, i_mem_data;
    logic [4:0] i_field_length_first = 0, i_field_length_second = 0;
    logic i_field_extend_first = 0, i_field_extend_second = 0, i_mem_valid;
    logic [31:0] i_reg_rd_data = 0, o_mem_word_addr, o_reg_wr_data;
    logic o_instr_ready, o_illegal, o_mem_rd, o_reg_wr, o_done;
    logic o_flag_n, o_flag_z, o_flag_v, o_flags_wr;
    logic [4:0] o_reg_rd_num, o_reg_wr_num;
    int failures = 0, comparisons = 0;
    field_move_displaced_to_register uut (.*);
    fmove_mem u_mem (.i_ref_clk(i_ref_clk), .i_rd(o_mem_rd),
        .i_addr(o_mem_word_addr), .o_valid(i_mem_valid), .o_data(i_mem_data));
    initial forever #4 i_ref_clk = ~i_ref_clk;
    task chk(input logic [31:0] got, exp, input string n);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, exp, got);
        end
    endtask
    task test_done;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task run(input logic [15:0] op, disp, input logic [31:0] r,
             input logic [4:0] ln, input logic sx);
        logic [31:0] ba, v, wa;
        int k;
        ba = r + {{16{disp[15]}}, disp};
        wa = ba >> 4;
        v = 32'({u_mem.word(wa + 2), u_mem.word(wa + 1), u_mem.word(wa)}
            >> ba[3:0]);
        if (ln != 0) v = (sx && v[ln - 1]) ? v | ~0 << ln : v & ~(~0 << ln);
        @(posedge i_ref_clk);
        // The unused set gets inverted values so a wrong pick shows
        {i_field_length_first, i_field_extend_first} <=
            op[9] ? ~{ln, sx} : {ln, sx};
        {i_field_length_second, i_field_extend_second} <=
            op[9] ? {ln, sx} : ~{ln, sx};
        i_reg_rd_data <= r;
        i_instr_word <= op;
        i_instr_valid <= 1;
        @(posedge i_ref_clk);
        i_instr_word <= disp;
        #1 chk(o_reg_rd_num, {op[4], op[8:5]}, "source");
        @(posedge i_ref_clk);
        i_instr_valid <= 0;
        k = 0;
        while (o_reg_wr !== 1'b1 && k < 40) begin
            @(posedge i_ref_clk);
            #1 k++;
        end
        chk(o_reg_wr, 1, "write");
        chk(o_reg_wr_data, v, "data");
        chk(o_reg_wr_num, {op[4], op[3:0]}, "dest");
        chk({o_flag_n, o_flag_z, o_flag_v},
            {v[31], v == 0, 1'b0}, "nzv");
    endtask
    initial begin
        void'($urandom(96540));
        repeat (5) @(posedge i_ref_clk);
        i_resetn <= 1;
        @(posedge i_ref_clk);
        i_instr_word <= 16'hb0ff;
        i_instr_valid <= 1;
        @(posedge i_ref_clk);
        i_instr_valid <= 0;
        #1 chk(o_illegal, 1, "illegal");
        run(16'hb412, 16'h0000, 0, 5'd8, 1);
        run(16'hb6a5, 16'h8000, 32'h0001d530, 5'd1, 1);
        for (int i = 0; i < 40; i++)
            run({6'h2d, 10'($urandom)},
                16'($urandom), $urandom, 5'(i), 1'($urandom));
        test_done;
    end
    initial begin
        #100000;
        failures++;
        test_done;
    end
endmodule // test_field_move_displaced_to_register
